/* sppg_pkg.sv */
// Notes on behaviour
// - Pulse output works only while the mode word's low byte holds BCD 30.
// - Profiles: automatic trapezoid, step trapezoid, or velocity control (speed and direction).
// - The pulse rate never exceeds 10 kHz.
// - A running pulse rate never falls below 40 pulses per second.
// - For automatic trapezoid, the block works out the whole profile from the acceleration, deceleration, position and velocity inputs.
// - Once started, the pulse train runs on its own without host involvement.
// - Each emitted pulse is one motion increment and moves the position by one.
// - Output format is either step plus direction, or separate CW and CCW pulses.
// - Pulses leave on the first two DC output terminals.
// - Host start and load commands arrive on their own inputs, separate from the pulse terminals.
// - The interrupt input acts as an interrupt only for trapezoid profiles, else a plain input.
// - All four discrete inputs stay readable by the host in this mode.
// - Targets may be absolute or relative to the current position.
// - Current position is a double-word counter split into low and high halves.
// - Done flag sets when a profile completes and clears when start turns on.
// - Start begins motion, dropping it stops; restart is skipped when already at target.
// - When stopped with start off, a load command's rising edge presets the position.
// - With interrupt option, pulse until the interrupt input turns on, then emit the target count.
package sppg_pkg;

    localparam int unsigned CLK_PERIOD_NS  = 4;
    localparam logic [27:0] CLK_HZ         = 28'hEE6B280;

    localparam logic [7:0]  MODE_PULSE_OUT = 8'h30;

    localparam int          VEL_W          = 14;
    localparam int          POS_W          = 32;
    localparam int          TGT_W          = 24;

    localparam logic [13:0] VEL_MAX_PPS    = 14'h2710;
    localparam logic [13:0] VEL_MIN_PPS    = 14'h0028;
    localparam logic [3:0]  VEL_UNIT_PPS   = 4'hA;

    localparam int unsigned PULSE_HI_NS    = 2000;
    localparam int unsigned PULSE_HI_CYC   = (PULSE_HI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned DIR_SETUP_NS   = 5000;
    localparam int unsigned DIR_SETUP_CYC  = (DIR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned TICK_US        = 1000;
    localparam int unsigned TICK_CYC       = TICK_US * 1000 / CLK_PERIOD_NS;
    localparam int unsigned TICKS_PER_S    = 1000000 / TICK_US;
    localparam logic [11:0] BRAKE_K        = 12'(2 * TICKS_PER_S);

    // Profile kind nibble fields
    localparam int          KIND_REL_BIT   = 3;
    localparam int          KIND_AUTO_BIT  = 2;
    localparam int          KIND_STEP_BIT  = 1;
    localparam int          KIND_INT_BIT   = 0;

    localparam logic        FMT_PULSE_DIR  = 1'b1;
    localparam logic        FMT_CW_CCW     = 1'b0;

    typedef enum logic [1:0] {
        SPPG_IDLE  = 2'b00,
        SPPG_SETUP = 2'b01,
        SPPG_MOVE  = 2'b10
    } sppg_state_t;

endpackage : sppg_pkg

/* sppg_rate_gen.sv */
`timescale 1ns/1ps
module sppg_rate_gen
(
    input  wire logic                      core_clk_i,
    input  wire logic                      rst_i,
    input  wire logic                      run_i,
    input  wire logic [sppg_pkg::VEL_W-1:0] velocity_i,
    output logic                           step_o,
    output logic                           level_o
);

    logic [27:0] phase;
    logic [28:0] phase_sum;
    logic [15:0] hi_cnt;

    assign phase_sum = {1'b0, phase} + {15'h0000, velocity_i};

    ////////////////////////////////////////////////////////////////////////
    // Phase accumulator gives an exact average rate without a divider
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            phase  <= 28'h0000000;
            step_o <= 1'b0;
        end
        else if (!run_i)
        begin
            phase  <= 28'h0000000;
            step_o <= 1'b0;
        end
        else if (phase_sum >= {1'b0, sppg_pkg::CLK_HZ})
        begin
            phase  <= 28'(phase_sum - {1'b0, sppg_pkg::CLK_HZ});
            step_o <= 1'b1;
        end
        else
        begin
            phase  <= phase_sum[27:0];
            step_o <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Fixed high time, well under half the 10 kHz period; never cut, as the step is already counted
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            hi_cnt  <= 16'h0000;
            level_o <= 1'b0;
        end
        else if (step_o)
        begin
            hi_cnt  <= 16'(sppg_pkg::PULSE_HI_CYC - 1);
            level_o <= 1'b1;
        end
        else if (hi_cnt != 16'h0000)
        begin
            hi_cnt <= hi_cnt - 16'h0001;
        end
        else
        begin
            level_o <= 1'b0;
        end
    end

endmodule : sppg_rate_gen

/* sppg_top.sv */
`timescale 1ns/1ps
module sppg_top
#(
    parameter int unsigned TICK_CYC = sppg_pkg::TICK_CYC
)
(
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    input  wire logic [15:0] mode_select_word_i,
    input  wire logic        output_format_i,
    input  wire logic [3:0]  profile_kind_i,
    input  wire logic [11:0] target_velocity_i,
    input  wire logic [23:0] target_position_i,
    input  wire logic [15:0] accel_rate_i,
    input  wire logic [15:0] decel_rate_i,
    input  wire logic [15:0] step_size_i,
    input  wire logic [7:0]  step_hold_i,
    input  wire logic        velocity_reverse_i,
    input  wire logic        start_profile_i,
    input  wire logic        load_position_i,
    input  wire logic [31:0] preload_value_i,
    input  wire logic        discrete_input_0_i,
    input  wire logic        external_interrupt_input_i,
    input  wire logic        discrete_input_2_i,
    input  wire logic        discrete_input_3_i,
    output logic             pulse_out_a_o,
    output logic             pulse_out_b_o,
    output logic [15:0]      position_counter_low_o,
    output logic [15:0]      position_counter_high_o,
    output logic             profile_done_flag_o,
    output logic             motion_busy_o,
    output logic [3:0]       input_state_o
);

    sppg_pkg::sppg_state_t   state;
    logic                    mode_on;
    logic                    start_q;
    logic                    load_q;
    logic                    ext_q;
    logic                    start_rise;
    logic                    load_rise;
    logic                    ext_rise;
    logic [3:0]              kind_q;
    logic                    is_vel_kind;
    logic                    dir;
    logic                    waiting_int;
    logic [31:0]             remaining;
    logic [31:0]             position;
    logic [31:0]             delta;
    logic [31:0]             delta_mag;
    logic [31:0]             tgt_ext;
    logic [31:0]             tgt_mag;
    logic [15:0]             setup_cnt;
    logic [31:0]             tick_cnt;
    logic                    tick;
    logic [7:0]              hold_cnt;
    logic [sppg_pkg::VEL_W-1:0] vel;
    logic [sppg_pkg::VEL_W-1:0] vel_target;
    logic [15:0]             vel_scaled;
    logic [27:0]             vel_sq;
    logic [63:0]             brake_dist;
    logic                    braking;
    logic                    ramp_evt;
    logic [16:0]             up_amt;
    logic [16:0]             vel_up;
    logic [16:0]             vel_dn;
    logic                    set_done;
    logic                    step;
    logic                    level;

    ////////////////////////////////////////////////////////////////////////
    // Decode and edges
    assign mode_on     = mode_select_word_i[7:0] == sppg_pkg::MODE_PULSE_OUT;
    assign start_rise  = start_profile_i & ~start_q;
    assign load_rise   = load_position_i & ~load_q;
    // Interrupt edge only counts for trapezoid kinds
    assign ext_rise    = external_interrupt_input_i & ~ext_q & ~is_vel_kind;
    assign is_vel_kind = ~kind_q[sppg_pkg::KIND_AUTO_BIT] & ~kind_q[sppg_pkg::KIND_STEP_BIT];

    assign tgt_ext   = {{8{target_position_i[23]}}, target_position_i};
    assign tgt_mag   = tgt_ext[31] ? 32'(-tgt_ext) : tgt_ext;
    assign delta     = profile_kind_i[sppg_pkg::KIND_REL_BIT] ? tgt_ext : 32'(tgt_ext - position);
    assign delta_mag = delta[31] ? 32'(-delta) : delta;

    // Clamp the commanded rate into the supported band
    assign vel_scaled = 16'(target_velocity_i * sppg_pkg::VEL_UNIT_PPS);
    always_comb
    begin
        if (vel_scaled > {2'b00, sppg_pkg::VEL_MAX_PPS})
            vel_target = sppg_pkg::VEL_MAX_PPS;
        else if (vel_scaled < {2'b00, sppg_pkg::VEL_MIN_PPS})
            vel_target = sppg_pkg::VEL_MIN_PPS;
        else
            vel_target = vel_scaled[sppg_pkg::VEL_W-1:0];
    end

    // Brake when the stopping distance v^2/(2a) reaches what is left
    assign vel_sq     = 28'(vel * vel);
    assign brake_dist = 64'(remaining) * 64'(decel_rate_i) * 64'(sppg_pkg::BRAKE_K);
    assign braking    = ~waiting_int & ~is_vel_kind & (brake_dist <= {36'h000000000, vel_sq});

    assign tick     = tick_cnt == 32'(TICK_CYC - 1);
    assign ramp_evt = kind_q[sppg_pkg::KIND_AUTO_BIT] ? tick : (tick & (hold_cnt == 8'h00));
    assign up_amt   = kind_q[sppg_pkg::KIND_AUTO_BIT] ? {1'b0, accel_rate_i} : {1'b0, step_size_i};
    assign vel_up   = {3'b000, vel} + up_amt;
    assign vel_dn   = {3'b000, vel} - {1'b0, decel_rate_i};

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            start_q <= 1'b0;
            load_q  <= 1'b0;
            ext_q   <= 1'b0;
        end
        else
        begin
            start_q <= start_profile_i;
            load_q  <= load_position_i;
            ext_q   <= external_interrupt_input_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Motion sequencer
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state       <= sppg_pkg::SPPG_IDLE;
            kind_q      <= 4'h0;
            dir         <= 1'b0;
            waiting_int <= 1'b0;
            remaining   <= 32'h00000000;
            setup_cnt   <= 16'h0000;
            set_done    <= 1'b0;
        end
        else
        begin
            set_done <= 1'b0;
            unique case (state)
                sppg_pkg::SPPG_IDLE:
                begin
                    if (mode_on && start_rise)
                    begin
                        kind_q      <= profile_kind_i;
                        waiting_int <= profile_kind_i[sppg_pkg::KIND_INT_BIT] &
                                       (profile_kind_i[sppg_pkg::KIND_AUTO_BIT] |
                                        profile_kind_i[sppg_pkg::KIND_STEP_BIT]);
                        remaining   <= delta_mag;
                        setup_cnt   <= 16'(sppg_pkg::DIR_SETUP_CYC - 1);
                        if (!profile_kind_i[sppg_pkg::KIND_AUTO_BIT] && !profile_kind_i[sppg_pkg::KIND_STEP_BIT])
                        begin
                            dir   <= velocity_reverse_i;
                            state <= sppg_pkg::SPPG_SETUP;
                        end
                        else if (delta_mag == 32'h00000000 && !profile_kind_i[sppg_pkg::KIND_INT_BIT])
                        begin
                            set_done <= 1'b1;
                        end
                        else
                        begin
                            dir   <= delta[31];
                            state <= sppg_pkg::SPPG_SETUP;
                        end
                    end
                end
                sppg_pkg::SPPG_SETUP:
                begin
                    // Direction is already out; hold off the first pulse
                    if (!start_profile_i || !mode_on)
                        state <= sppg_pkg::SPPG_IDLE;
                    else if (setup_cnt == 16'h0000)
                        state <= sppg_pkg::SPPG_MOVE;
                    else
                        setup_cnt <= setup_cnt - 16'h0001;
                end
                sppg_pkg::SPPG_MOVE:
                begin
                    if (!start_profile_i || !mode_on)
                    begin
                        state <= sppg_pkg::SPPG_IDLE;
                    end
                    else if (waiting_int)
                    begin
                        if (ext_rise)
                        begin
                            waiting_int <= 1'b0;
                            remaining   <= tgt_mag;
                        end
                    end
                    else if (!is_vel_kind)
                    begin
                        if (remaining == 32'h00000000 || (step && remaining == 32'h00000001))
                        begin
                            remaining <= 32'h00000000;
                            set_done  <= 1'b1;
                            state     <= sppg_pkg::SPPG_IDLE;
                        end
                        else if (step)
                        begin
                            remaining <= remaining - 32'h00000001;
                        end
                    end
                end
                default:
                begin
                    state <= sppg_pkg::SPPG_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Velocity ramp
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            vel      <= sppg_pkg::VEL_MIN_PPS;
            tick_cnt <= 32'h00000000;
            hold_cnt <= 8'h00;
        end
        else if (state != sppg_pkg::SPPG_MOVE)
        begin
            vel      <= sppg_pkg::VEL_MIN_PPS;
            tick_cnt <= 32'h00000000;
            hold_cnt <= step_hold_i;
        end
        else
        begin
            tick_cnt <= tick ? 32'h00000000 : tick_cnt + 32'h00000001;
            if (tick)
                hold_cnt <= (hold_cnt == 8'h00) ? step_hold_i : hold_cnt - 8'h01;
            if (is_vel_kind)
                vel <= vel_target;
            else if (ramp_evt)
            begin
                if (braking || vel > vel_target)
                    vel <= (vel_dn[16] || vel_dn < {3'b000, sppg_pkg::VEL_MIN_PPS}) ?
                           sppg_pkg::VEL_MIN_PPS : vel_dn[sppg_pkg::VEL_W-1:0];
                else if (vel < vel_target)
                    vel <= (vel_up > {3'b000, vel_target}) ? vel_target : vel_up[sppg_pkg::VEL_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    sppg_rate_gen u_rate
    (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .run_i      (state == sppg_pkg::SPPG_MOVE),
        .velocity_i (vel),
        .step_o     (step),
        .level_o    (level)
    );

    ////////////////////////////////////////////////////////////////////////
    // Position counter
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
            position <= 32'h00000000;
        else if (state == sppg_pkg::SPPG_MOVE && step)
            position <= dir ? position - 32'h00000001 : position + 32'h00000001;
        else if (state == sppg_pkg::SPPG_IDLE && !start_profile_i && load_rise)
            position <= preload_value_i;
    end

    // Set beats clear when both land together
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
            profile_done_flag_o <= 1'b0;
        else if (set_done)
            profile_done_flag_o <= 1'b1;
        else if (start_rise)
            profile_done_flag_o <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Output pins, registered
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pulse_out_a_o           <= 1'b0;
            pulse_out_b_o           <= 1'b0;
            position_counter_low_o  <= 16'h0000;
            position_counter_high_o <= 16'h0000;
            motion_busy_o           <= 1'b0;
            input_state_o           <= 4'h0;
        end
        else
        begin
            if (!mode_on)
            begin
                pulse_out_a_o <= 1'b0;
                pulse_out_b_o <= 1'b0;
            end
            else if (output_format_i == sppg_pkg::FMT_PULSE_DIR)
            begin
                pulse_out_a_o <= level;
                pulse_out_b_o <= dir;
            end
            else
            begin
                pulse_out_a_o <= level & ~dir;
                pulse_out_b_o <= level & dir;
            end
            position_counter_low_o  <= position[15:0];
            position_counter_high_o <= position[31:16];
            motion_busy_o           <= state != sppg_pkg::SPPG_IDLE;
            input_state_o           <= {discrete_input_3_i, discrete_input_2_i,
                                        external_interrupt_input_i, discrete_input_0_i};
        end
    end

endmodule : sppg_top

/* sppg_drive_model.sv */
`timescale 1ns/1ps
module sppg_drive_model
(
    input  wire logic          core_clk_i,
    input  wire logic          rst_i,
    input  wire logic          format_i,
    input  wire logic          step_a_i,
    input  wire logic          step_b_i,
    output logic signed [31:0] moved_o
);
    logic a_q;
    logic b_q;

    // The drive acts on rising edges only and is blind to pulse width
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            a_q     <= 1'b0;
            b_q     <= 1'b0;
            moved_o <= '0;
        end
        else
        begin
            a_q <= step_a_i;
            b_q <= step_b_i;
            if (step_a_i && !a_q)
                moved_o <= (format_i && step_b_i) ? moved_o - 1 : moved_o + 1;
            else if (!format_i && step_b_i && !b_q)
                moved_o <= moved_o - 1;
        end
    end
endmodule : sppg_drive_model

/* sppg_top_props.sv */
`timescale 1ns/1ps
module sppg_top_props
#(
    parameter int unsigned TICK_CYC = sppg_pkg::TICK_CYC
)
(
    input wire logic        core_clk_i,
    input wire logic        rst_i,
    input wire logic [15:0] mode_select_word_i,
    input wire logic        output_format_i,
    input wire logic        start_profile_i,
    input wire logic        load_position_i,
    input wire logic [31:0] preload_value_i,
    input wire logic        discrete_input_0_i,
    input wire logic        external_interrupt_input_i,
    input wire logic        discrete_input_2_i,
    input wire logic        discrete_input_3_i,
    input wire logic        pulse_out_a_o,
    input wire logic        pulse_out_b_o,
    input wire logic [15:0] position_counter_low_o,
    input wire logic [15:0] position_counter_high_o,
    input wire logic        profile_done_flag_o,
    input wire logic        motion_busy_o,
    input wire logic [3:0]  input_state_o
);
    logic [31:0] pos;
    logic        mode_on;
    logic        a_q;
    logic [15:0] gap_cnt;

    assign pos     = {position_counter_high_o, position_counter_low_o};
    assign mode_on = mode_select_word_i[7:0] == sppg_pkg::MODE_PULSE_OUT;

    // Saturates so a long idle spell never wraps into a false short gap
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            a_q     <= 1'b0;
            gap_cnt <= 16'hFFFF;
        end
        else
        begin
            a_q <= pulse_out_a_o;
            if (pulse_out_a_o && !a_q)
                gap_cnt <= 16'h0000;
            else if (gap_cnt != 16'hFFFF)
                gap_cnt <= gap_cnt + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    a_mode_off_quiet: assert property (!mode_on [*3] |-> !pulse_out_a_o && !pulse_out_b_o && !motion_busy_o)
        else $error("pins or busy active with mode off");
    a_rate_ceiling: assert property ($rose(pulse_out_a_o) |-> gap_cnt >= 16'h61A7)
        else $error("pulse spacing below 10 kHz period");
    a_step_moves_pos: assert property ($rose(pulse_out_a_o) |-> pos != $past(pos, 3))
        else $error("pulse without position step");
    a_pos_single_step: assert property (motion_busy_o && $past(motion_busy_o)
        |-> (pos - $past(pos)) inside {32'h00000000, 32'h00000001, 32'hFFFFFFFF})
        else $error("position jumped by more than one");
    a_dir_settled: assert property ($rose(pulse_out_a_o) && output_format_i
        |-> $stable(pulse_out_b_o) && pulse_out_b_o == $past(pulse_out_b_o, 8))
        else $error("direction moved near pulse");
    a_done_clear_cause: assert property ($fell(profile_done_flag_o)
        |-> ($past(start_profile_i) && !$past(start_profile_i, 2))
            || ($past(start_profile_i, 2) && !$past(start_profile_i, 3)))
        else $error("done cleared without start edge");
    a_load_preset: assert property ($rose(load_position_i) && !start_profile_i && !$past(start_profile_i)
        && !motion_busy_o && !$past(motion_busy_o) |-> ##2 pos == $past(preload_value_i, 2))
        else $error("preload not applied");
    a_inputs_mirror: assert property (!$past(rst_i) |-> input_state_o == $past({discrete_input_3_i,
        discrete_input_2_i, external_interrupt_input_i, discrete_input_0_i}))
        else $error("input state not mirrored");
endmodule : sppg_top_props

bind sppg_top sppg_top_props #(.TICK_CYC(TICK_CYC)) u_props (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .mode_select_word_i(mode_select_word_i), .output_format_i(output_format_i),
    .start_profile_i(start_profile_i), .load_position_i(load_position_i), .preload_value_i(preload_value_i),
    .discrete_input_0_i(discrete_input_0_i), .external_interrupt_input_i(external_interrupt_input_i),
    .discrete_input_2_i(discrete_input_2_i), .discrete_input_3_i(discrete_input_3_i),
    .pulse_out_a_o(pulse_out_a_o), .pulse_out_b_o(pulse_out_b_o),
    .position_counter_low_o(position_counter_low_o), .position_counter_high_o(position_counter_high_o),
    .profile_done_flag_o(profile_done_flag_o), .motion_busy_o(motion_busy_o), .input_state_o(input_state_o));

/* step_pulse_profile_generator_tb.sv */
`timescale 1ns/1ps
module step_pulse_profile_generator_tb;
    // Short ramp tick keeps the run small; braking point shifts, not rates
    localparam int unsigned TICK = 100;

    logic               core_clk_i = 1'b0;
    logic               rst_i      = 1'b1;
    logic [15:0]        mode       = 16'h0030;
    logic               fmt        = 1'b1;
    logic [3:0]         kind       = 4'h0;
    logic [11:0]        vel        = 12'hFFF;
    logic [23:0]        tgt        = 24'h000000;
    logic               rev        = 1'b0;
    logic               start      = 1'b0;
    logic               load       = 1'b0;
    logic [31:0]        preload    = 32'h00000000;
    logic [3:0]         din        = 4'h0;
    logic               pa;
    logic               pb;
    logic               done;
    logic               busy;
    logic [15:0]        pos_lo;
    logic [15:0]        pos_hi;
    logic [3:0]         din_seen;
    logic signed [31:0] moved;
    int                 err_count       = 0;
    int                 samples_checked = 0;

    always #2 core_clk_i = ~core_clk_i;

    sppg_top #(.TICK_CYC(TICK)) u_dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .mode_select_word_i(mode),
        .output_format_i(fmt), .profile_kind_i(kind), .target_velocity_i(vel), .target_position_i(tgt),
        .accel_rate_i(16'h0100), .decel_rate_i(16'hFFFF), .step_size_i(16'h0100), .step_hold_i(8'h01),
        .velocity_reverse_i(rev), .start_profile_i(start), .load_position_i(load), .preload_value_i(preload),
        .discrete_input_0_i(din[0]), .external_interrupt_input_i(din[1]), .discrete_input_2_i(din[2]),
        .discrete_input_3_i(din[3]), .pulse_out_a_o(pa), .pulse_out_b_o(pb),
        .position_counter_low_o(pos_lo), .position_counter_high_o(pos_hi), .profile_done_flag_o(done),
        .motion_busy_o(busy), .input_state_o(din_seen));

    sppg_drive_model u_drive (.core_clk_i(core_clk_i), .rst_i(rst_i), .format_i(fmt), .step_a_i(pa),
        .step_b_i(pb), .moved_o(moved));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk_i);
    endtask : cyc

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("FAIL t=%0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask : chk

    // Bounded wait: one pulse at 10 kHz is 25000 cycles
    task automatic wait_pos(input logic [31:0] exp);
        int n;
        n = 0;
        while ({pos_hi, pos_lo} !== exp && n < 30000)
        begin
            cyc(1);
            n++;
        end
        chk({pos_hi, pos_lo}, exp, "position");
    endtask : wait_pos

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_inputs_load;
        for (int i = 0; i < 5; i++)
        begin
            din = (i == 4) ? 4'hA : 4'(1 << i);
            cyc(2);
            chk(32'(din_seen), 32'(din), "inputs");
        end
        preload = 32'h00012345;
        load = 1'b1;
        cyc(3);
        load = 1'b0;
        chk({pos_hi, pos_lo}, 32'h00012345, "preload");
        mode = 16'h0020;
        start = 1'b1;
        cyc(4);
        chk(32'(busy), 32'h0, "mode off start");
        preload = 32'h00000042;
        load = 1'b1;
        cyc(3);
        chk({pos_hi, pos_lo}, 32'h00012345, "load while start");
        load = 1'b0;
        start = 1'b0;
        mode = 16'h0030;
        cyc(2);
        $display("test inputs_load done");
    endtask : t_inputs_load

    task automatic t_zero_move;
        for (int i = 0; i < 2; i++)
        begin
            kind = i ? 4'h4 : 4'hC;
            tgt = i ? 24'h012345 : 24'h000000;
            start = 1'b1;
            cyc(4);
            chk({30'h0, done, busy}, 32'h2, "zero move");
            start = 1'b0;
            cyc(2);
        end
        $display("test zero_move done");
    endtask : t_zero_move

    // Clamped rate, high mode byte ignored, abort leaves done clear
    task automatic t_vel_dir;
        mode = 16'hAB30;
        kind = 4'h0;
        rev = 1'b1;
        start = 1'b1;
        cyc(4);
        chk({29'h0, done, busy, pb}, 32'h3, "dir start");
        wait_pos(32'h00012344);
        wait_pos(32'h00012343);
        cyc(2);
        chk(moved, 32'hFFFFFFFE, "drive count");
        start = 1'b0;
        cyc(3);
        chk({30'h0, done, busy}, 32'h0, "abort");
        $display("test vel_dir done");
    endtask : t_vel_dir

    task automatic t_cw_mode_off;
        cyc(500);
        fmt = 1'b0;
        kind = 4'hD;
        tgt = 24'h000001;
        din = 4'h8;
        vel = 12'h3E8;
        start = 1'b1;
        cyc(1300);
        din = 4'hA;
        wait_pos(32'h00012344);
        cyc(2);
        chk(moved, 32'hFFFFFFFF, "cw count");
        chk({29'h0, done, busy, pa}, 32'h5, "int done");
        start = 1'b0;
        cyc(2);
        start = 1'b1;
        cyc(4);
        mode = 16'h0000;
        cyc(3);
        chk({29'h0, busy, pa, pb}, 32'h0, "mode drop");
        start = 1'b0;
        $display("test cw_mode_off done");
    endtask : t_cw_mode_off

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        cyc(6);
        rst_i = 1'b0;
        cyc(2);
        chk({27'h0, busy, done, pa, pb, |{pos_hi, pos_lo}}, 32'h0, "reset state");
        t_inputs_load;
        t_zero_move;
        t_vel_dir;
        t_cw_mode_off;
        end_sim;
    end

    initial
    begin
        #(4 * 95000);
        err_count++;
        $display("FAIL t=%0t watchdog expired", $time);
        end_sim;
    end
endmodule : step_pulse_profile_generator_tb
